// ### hw/msbc_sync.sv
// Purpose: Multi-flop synchroniser for asynchronous pin levels.
// Assumes: Each bit is an independent level.
// Notes: Only the last stage may be used by other logic.
`default_nettype none
module msbc_sync #(
  parameter int W = 3,
  parameter int STAGES = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Levels in and out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stg [STAGES];
  logic [W-1:0] next_stg [STAGES];

  // Shift the pin levels along the chain.
  always_comb begin
    next_stg[0] = d;
    for (int i = 1; i < STAGES; i++) begin
      next_stg[i] = stg[i-1];
    end
  end

  // Register the chain; reset loads RST_VAL into every stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STAGES; i++) begin
        stg[i] <= RST_VAL;
      end
    end else begin
      stg <= next_stg;
    end
  end

  assign q = stg[STAGES-1];
endmodule
`default_nettype wire

// ### hw/msbc_timer.sv
// Purpose: Counts consecutive cycles of a run level up to a limit.
// Assumes: The limit is stable while run is high.
// Notes: Dropping run clears the count at once.
`default_nettype none
module msbc_timer (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Timer control.
  msbc_cnt_if.cnt t
);
  logic [msbc_pkg::CNT_W-1:0] cnt;
  logic [msbc_pkg::CNT_W-1:0] next_cnt;

  // Count while running, saturate at the limit.
  always_comb begin
    if (!t.run) begin
      next_cnt = '0;
    end else if (cnt == t.limit) begin
      next_cnt = cnt;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  // Register the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign t.hit = t.run && (cnt == t.limit);
endmodule
`default_nettype wire

// ### hw/msbc_top.sv
// Purpose: Sideband control of a pluggable module: reset, select,
//   init mode, presence, alert and serial bus gating, with APB registers.
// Assumes: Pins are levels; the serial engine sits outside this block.
// Notes: Pull-ups are resolved at the pad from the pull enables.
// How it works
// [RQ1] Reset low beyond 2 us fully resets.
// [RQ2] Init interval starts at reset release.
// [RQ3] Reset input weakly pulled up.
// [RQ4] Presence line grounded inside the module.
// [RQ5] Alert low on fault, loss or critical; there is no critical input, the alert follows the unmasked status bits.
// [RQ6] Host reads status to find the cause.
// [RQ7] Serial bus answered only while selected.
// [RQ8] Select input weakly pulled up.
// [RQ9] Software mode holds low power until allowed.
// [RQ10] Hardware mode goes high power after init.
// [RQ11] Host keeps init mode pin constant.
// [RQ12] Init mode input weakly pulled up.
// [RQ13] Deselect releases both bus lines quickly.
// [RQ14] Host selects 2 ms before bus traffic.
// [RQ15] Clock stretching never exceeds 500 us.
// [RQ16] Loss indication follows receive low power alarm.
// [RQ17] Control pins pass multi-flop synchronisers.
// [RQ18] Short reset pulses are ignored as glitches.
//
// Register access over APB and the placing of the registers were decided locally.
`default_nettype none
module msbc_top #(
  parameter int STRETCH_MAX_CYC = msbc_pkg::STRETCH_MAX_CYC,
  parameter int MGMT_INIT_CYC = msbc_pkg::MGMT_INIT_CYC,
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Host sideband pins.
  input wire logic module_reset_n,
  input wire logic bus_select_n,
  input wire logic init_control_select,
  output logic presence_detect_n,
  output logic host_alert_n,
  output logic reset_pullup_en,
  output logic select_pullup_en,
  output logic init_pullup_en,
  // Serial bus pins, open drain.
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Internal serial engine.
  input wire logic mgmt_scl_hold,
  input wire logic mgmt_sda_low,
  output logic mgmt_enable,
  output logic mgmt_scl_in,
  output logic mgmt_sda_in,
  // Internal status and power control.
  input wire logic fault_alarm,
  input wire logic rx_low_power_alarm,
  output logic receive_signal_loss,
  output logic high_power_en,
  output logic module_in_reset
);
  localparam int NE = msbc_pkg::NUM_EV;

  logic rst_s, sel_s, init_s;
  msbc_pkg::msbc_state_t state, next_state;
  logic sw_mode, next_sw_mode;
  logic ctrl_hp, next_ctrl_hp;
  logic [NE-1:0] status, next_status, mask, next_mask, ev;
  logic fault_d, los_d, next_fault_d, next_los_d;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, wr_en, rd_hit;
  logic next_scl_oe, next_sda_oe, next_irq, sel_ok;
  logic rst_hit, init_hit, stretch_hit;

  msbc_cnt_if rst_t ();
  msbc_cnt_if init_t ();
  msbc_cnt_if str_t ();

  // [RQ17] Synchronise pins
  // The reset pin starts asserted, so init mode is caught after it settled.
  msbc_sync #(
    .W(3),
    .STAGES(SYNC_STAGES),
    .RST_VAL(3'h3)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({module_reset_n, bus_select_n, init_control_select}),
    .q({rst_s, sel_s, init_s})
  );

  // [RQ18] Reset width counter
  assign rst_t.run = !rst_s;
  assign rst_t.limit = msbc_pkg::CNT_W'(msbc_pkg::RESET_MIN_CYC);
  assign rst_hit = rst_t.hit;
  msbc_timer u_rst_tmr (.pclk(pclk), .presetn(presetn), .t(rst_t));

  // Management initialization interval, run in its own state.
  assign init_t.run = (state == msbc_pkg::ST_MGMT_INIT);
  assign init_t.limit = msbc_pkg::CNT_W'(MGMT_INIT_CYC);
  assign init_hit = init_t.hit;
  msbc_timer u_init_tmr (.pclk(pclk), .presetn(presetn), .t(init_t));

  // [RQ15] Stretch limit timer
  assign str_t.run = sel_ok && mgmt_scl_hold;
  assign str_t.limit = msbc_pkg::CNT_W'(STRETCH_MAX_CYC);
  assign stretch_hit = str_t.hit;
  msbc_timer u_str_tmr (.pclk(pclk), .presetn(presetn), .t(str_t));

  // [RQ7] Selected while low
  assign sel_ok = !sel_s && (state != msbc_pkg::ST_RESET);

  // Power state machine with the init mode caught at reset release.
  always_comb begin
    next_state = state;
    next_sw_mode = sw_mode;
    unique case (state)
      msbc_pkg::ST_RESET: begin
        // [RQ2] Start init on release
        if (rst_s) begin
          next_state = msbc_pkg::ST_MGMT_INIT;
          next_sw_mode = init_s;
        end
      end
      msbc_pkg::ST_MGMT_INIT: begin
        // [RQ10] Hardware mode goes up
        if (init_hit) begin
          next_state = sw_mode ? msbc_pkg::ST_LOW_PWR
                               : msbc_pkg::ST_HIGH_PWR;
        end
      end
      msbc_pkg::ST_LOW_PWR: begin
        // [RQ9] Wait for software
        if (ctrl_hp) begin
          next_state = msbc_pkg::ST_HIGH_PWR;
        end
      end
      msbc_pkg::ST_HIGH_PWR: begin
        if (sw_mode && !ctrl_hp) begin
          next_state = msbc_pkg::ST_LOW_PWR;
        end
      end
    endcase
    // [RQ1] Complete reset entry
    if (rst_hit) begin
      next_state = msbc_pkg::ST_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= msbc_pkg::ST_RESET;
      sw_mode <= 1'b1;
    end else begin
      state <= next_state;
      sw_mode <= next_sw_mode;
    end
  end

  // APB decode: one wait state, write lands on the completing edge.
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_hit = (paddr == msbc_pkg::ADDR_CTRL) ||
                  (paddr == msbc_pkg::ADDR_STATUS) ||
                  (paddr == msbc_pkg::ADDR_MASK) ||
                  (paddr == msbc_pkg::ADDR_STATE);

  // Event detection on rising alarm levels, a full reset and init end.
  always_comb begin
    next_fault_d = fault_alarm;
    next_los_d = rx_low_power_alarm;
    ev = '0;
    ev[msbc_pkg::EV_FAULT] = fault_alarm && !fault_d;
    ev[msbc_pkg::EV_LOS] = rx_low_power_alarm && !los_d;
    ev[msbc_pkg::EV_RESET] = rst_hit && (state != msbc_pkg::ST_RESET);
    ev[msbc_pkg::EV_INIT] = init_hit;
  end

  // Register updates; a set in the clearing cycle wins.
  always_comb begin
    next_ctrl_hp = ctrl_hp;
    next_mask = mask;
    next_status = status;
    if (wr_en && paddr == msbc_pkg::ADDR_CTRL) begin
      next_ctrl_hp = pwdata[msbc_pkg::CTRL_HP_BIT];
    end
    if (wr_en && paddr == msbc_pkg::ADDR_MASK) begin
      next_mask = pwdata[NE-1:0];
    end
    if (wr_en && paddr == msbc_pkg::ADDR_STATUS) begin
      next_status = status & ~pwdata[NE-1:0];
    end
    next_status = next_status | ev;
    // [RQ1] Restore user defaults
    if (rst_hit) begin
      next_ctrl_hp = msbc_pkg::CTRL_HP_RST;
      next_mask = msbc_pkg::MASK_RST;
    end
  end

  // Read data, ready and error for the access phase.
  always_comb begin
    next_pready = psel && penable && !pready;
    next_pslverr = next_pready && !rd_hit;
    next_prdata = '0;
    if (next_pready && !pwrite) begin
      unique case (paddr)
        msbc_pkg::ADDR_CTRL: next_prdata[msbc_pkg::CTRL_HP_BIT] = ctrl_hp;
        msbc_pkg::ADDR_STATUS: next_prdata[NE-1:0] = status;
        msbc_pkg::ADDR_MASK: next_prdata[NE-1:0] = mask;
        msbc_pkg::ADDR_STATE: begin
          next_prdata[msbc_pkg::ST_FSM_LSB +: 2] = state;
          next_prdata[msbc_pkg::ST_SEL_BIT] = sel_ok;
          next_prdata[msbc_pkg::ST_SWMODE_BIT] = sw_mode;
          next_prdata[msbc_pkg::ST_LOS_BIT] = receive_signal_loss;
          next_prdata[msbc_pkg::ST_RSTPIN_BIT] = rst_s;
          next_prdata[msbc_pkg::ST_HP_BIT] = high_power_en;
        end
        default: next_prdata = '0;
      endcase
    end
  end

  // [RQ13] Gate bus drivers
  always_comb begin
    next_scl_oe = sel_ok && mgmt_scl_hold && !stretch_hit;
    next_sda_oe = sel_ok && mgmt_sda_low;
    // [RQ5] Alert from unmasked status
    next_irq = |(status & mask);
  end

  // Output and register flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_hp <= msbc_pkg::CTRL_HP_RST;
      mask <= msbc_pkg::MASK_RST;
      status <= '0;
      fault_d <= 1'b0;
      los_d <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      host_alert_n <= 1'b1;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      mgmt_enable <= 1'b0;
      mgmt_scl_in <= 1'b1;
      mgmt_sda_in <= 1'b1;
      receive_signal_loss <= 1'b0;
      high_power_en <= 1'b0;
      module_in_reset <= 1'b1;
    end else begin
      ctrl_hp <= next_ctrl_hp;
      mask <= next_mask;
      status <= next_status;
      fault_d <= next_fault_d;
      los_d <= next_los_d;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
      host_alert_n <= !next_irq;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      // [RQ7] Hide traffic when deselected
      mgmt_enable <= sel_ok;
      mgmt_scl_in <= sel_ok ? scl_in : 1'b1;
      mgmt_sda_in <= sel_ok ? sda_in : 1'b1;
      // [RQ16] Loss follows alarm
      receive_signal_loss <= rx_low_power_alarm;
      high_power_en <= (next_state == msbc_pkg::ST_HIGH_PWR);
      module_in_reset <= (next_state == msbc_pkg::ST_RESET);
    end
  end

  // Constant pad controls: pull-ups on, presence tied low, drive low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // [RQ3] Reset pin pulled up
      reset_pullup_en <= 1'b1;
      // [RQ8] Select pin pulled up
      select_pullup_en <= 1'b1;
      // [RQ12] Init pin pulled up
      init_pullup_en <= 1'b1;
      // [RQ4] Presence grounded
      presence_detect_n <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      reset_pullup_en <= 1'b1;
      select_pullup_en <= 1'b1;
      init_pullup_en <= 1'b1;
      presence_detect_n <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // Checks on the sideband behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RESET_FULL: assert property ( // RQ1
    rst_hit |=> state == msbc_pkg::ST_RESET && mask == msbc_pkg::MASK_RST
      && module_in_reset)
    else $error("Full reset not taken.");
  AST_INIT_START: assert property ( // RQ2
    (state == msbc_pkg::ST_RESET && rst_s) |=>
      state == msbc_pkg::ST_MGMT_INIT)
    else $error("Init interval did not start at release.");
  AST_PULLUPS: assert property ( // RQ3
    reset_pullup_en && select_pullup_en && init_pullup_en)
    else $error("Pull-up enable dropped.");
  AST_PRESENT: assert property ( // RQ4
    !presence_detect_n && !scl_out && !sda_out)
    else $error("Presence line not grounded.");
  AST_ALERT: assert property ( // RQ5
    |(status & mask) |=> !host_alert_n && irq)
    else $error("Alert not raised for unmasked status.");
  AST_DESELECT: assert property ( // RQ13
    sel_s |=> !scl_oe && !sda_oe && !mgmt_enable)
    else $error("Bus lines held while deselected.");
  AST_SW_HOLD: assert property ( // RQ9
    (state == msbc_pkg::ST_LOW_PWR && !ctrl_hp && !rst_hit) |=>
      state == msbc_pkg::ST_LOW_PWR && !high_power_en)
    else $error("Left low power without software.");
  AST_HW_GO: assert property ( // RQ10
    (init_hit && !sw_mode && !rst_hit) |=> ##1 high_power_en)
    else $error("Hardware mode did not reach high power.");
  AST_STRETCH: assert property ( // RQ15
    stretch_hit |=> !scl_oe)
    else $error("Clock stretched beyond the limit.");
  AST_LOS: assert property ( // RQ16
    receive_signal_loss == $past(rx_low_power_alarm))
    else $error("Loss indication does not follow the alarm.");
  AST_GLITCH: assert property ( // RQ18
    (state != msbc_pkg::ST_RESET && !rst_s && !rst_hit) |=>
      state != msbc_pkg::ST_RESET)
    else $error("Short reset pulse was not ignored.");

  COV_FULL_RESET: cover property (rst_hit ##1
    (state == msbc_pkg::ST_RESET && module_in_reset));
  COV_HIGH_PWR: cover property (state == msbc_pkg::ST_LOW_PWR ##1
    state == msbc_pkg::ST_HIGH_PWR);
  COV_STRETCH: cover property (stretch_hit);
  COV_CLEAR_SET: cover property (wr_en && paddr == msbc_pkg::ADDR_STATUS
    && |ev);
endmodule
`default_nettype wire

// ### shared/msbc_cnt_if.sv
// Purpose: Carries a run level, a limit and a hit flag to a timer.
// Assumes: One controller and one timer per instance.
// Notes: The hit flag stays high while run holds at the limit.
`default_nettype none
interface msbc_cnt_if;
  logic run;
  logic [msbc_pkg::CNT_W-1:0] limit;
  logic hit;
  modport ctl (output run, output limit, input hit);
  modport cnt (input run, input limit, output hit);
endinterface
`default_nettype wire

// ### shared/msbc_pkg.sv
// Purpose: Constants and types shared by the module sideband control block.
// Assumes: pclk runs at 100 MHz.
// Notes: Register offsets are byte addresses on a 32-bit APB bus.
`default_nettype none
package msbc_pkg;
  // Clock period and the timing figures derived from it.
  localparam int PCLK_PERIOD_NS = 10;
  localparam int T_RESET_MIN_NS = 2000;
  // A low pulse must last strictly longer than the minimum, so add one.
  localparam int RESET_MIN_CYC =
    (T_RESET_MIN_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS + 1;
  localparam int T_STRETCH_MAX_US = 500;
  localparam int STRETCH_MAX_CYC = T_STRETCH_MAX_US * 1000 / PCLK_PERIOD_NS;
  localparam int MGMT_INIT_CYC = 1000;
  localparam int CNT_W = 32;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  // Event bits, shared by the status and mask registers.
  localparam int NUM_EV = 4;
  localparam int EV_FAULT = 0;
  localparam int EV_LOS = 1;
  localparam int EV_RESET = 2;
  localparam int EV_INIT = 3;
  // Control register fields and reset values.
  localparam int CTRL_HP_BIT = 0;
  localparam logic CTRL_HP_RST = 1'h0;
  localparam logic [NUM_EV-1:0] MASK_RST = 4'h3;
  // State register fields.
  localparam int ST_FSM_LSB = 0;
  localparam int ST_SEL_BIT = 4;
  localparam int ST_SWMODE_BIT = 5;
  localparam int ST_LOS_BIT = 6;
  localparam int ST_RSTPIN_BIT = 7;
  localparam int ST_HP_BIT = 8;
  // Module power and initialization states.
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_MGMT_INIT = 2'b01,
    ST_LOW_PWR = 2'b10,
    ST_HIGH_PWR = 2'b11
  } msbc_state_t;
endpackage
`default_nettype wire

// ### verification/msbc_host_model.sv
// Purpose: Host port side of the sideband pins, with board pull-ups.
// Assumes: The bench sets the host requests just after a clock edge.
// Notes: Undriven inputs resolve through the device's weak pull-ups.
`default_nettype none
module msbc_host_model (
  // Host requests.
  input wire logic inserted,
  input wire logic hold_reset,
  input wire logic select,
  input wire logic drive_init,
  input wire logic init_level,
  // Device pull enables and open-drain enables.
  input wire logic reset_pullup_en,
  input wire logic select_pullup_en,
  input wire logic init_pullup_en,
  input wire logic presence_detect_n,
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Resolved pin levels.
  output logic module_reset_n,
  output logic bus_select_n,
  output logic init_control_select,
  output logic presence_seen_n,
  output logic scl_line,
  output logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven pins float to the pull-up level, or to high impedance.
  assign module_reset_n = hold_reset ? 1'b0 : (reset_pullup_en ? 1'b1 : 1'bz);
  assign bus_select_n = select ? 1'b0 : (select_pullup_en ? 1'b1 : 1'bz);
  assign init_control_select = drive_init ? init_level :
    (init_pullup_en ? 1'b1 : 1'bz);
  assign presence_seen_n = inserted ? presence_detect_n : 1'b1;
  // The host resistor pulls each released open-drain line high.
  assign scl_line = !scl_oe;
  assign sda_line = !sda_oe;
endmodule
`default_nettype wire

// ### verification/tb_module_sideband_control.sv
// Purpose: Self-checking bench of the sideband control block.
// Assumes: Shortened stretch and init counts through parameters.
// Notes: Pins reach the device through the host model.
`default_nettype none
module tb_module_sideband_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, presence_detect_n, presence_n;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic rst_n, sel_n, init_sel, alert_n, rpu, spu, ipu, scl, sda;
  logic scl_out, scl_oe, sda_out, sda_oe, m_en, m_scl, m_sda, err;
  logic scl_hold = 1'b0, sda_low = 1'b0, fault = 1'b0, rx_alarm = 1'b0;
  logic hold_rst = 1'b0, sel = 1'b0, drv_init = 1'b0, init_lvl = 1'b0;
  logic loss, hp_en, in_rst;
  int mismatches = 0, cmp_count = 0, cycles = 0, n;
  // The clock toggles every half period of 10 ns.
  always #5 pclk = !pclk;
  msbc_top #(.STRETCH_MAX_CYC(20), .MGMT_INIT_CYC(10)) i_msbc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .module_reset_n(rst_n), .bus_select_n(sel_n),
    .init_control_select(init_sel), .presence_detect_n(presence_detect_n),
    .host_alert_n(alert_n), .reset_pullup_en(rpu), .select_pullup_en(spu),
    .init_pullup_en(ipu), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .mgmt_scl_hold(scl_hold), .mgmt_sda_low(sda_low), .mgmt_enable(m_en),
    .mgmt_scl_in(m_scl), .mgmt_sda_in(m_sda), .fault_alarm(fault),
    .rx_low_power_alarm(rx_alarm), .receive_signal_loss(loss),
    .high_power_en(hp_en), .module_in_reset(in_rst));
  msbc_host_model i_msbc_host_model (
    .inserted(1'b1), .hold_reset(hold_rst), .select(sel),
    .drive_init(drv_init), .init_level(init_lvl), .reset_pullup_en(rpu),
    .select_pullup_en(spu), .init_pullup_en(ipu),
    .presence_detect_n(presence_detect_n), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .module_reset_n(rst_n), .bus_select_n(sel_n),
    .init_control_select(init_sel), .presence_seen_n(presence_n),
    .scl_line(scl), .sda_line(sda));
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Compares one word.
  task automatic chk32(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits a bounded time for a level, then compares it.
  task automatic wait_lvl(input string nm, ref logic s, input logic v,
      input int lim);
    for (n = 0; n < lim && s !== v; n++) @(posedge pclk);
    chk32(nm, {31'h0, v}, {31'h0, s});
  endtask
  // One APB transfer; waits for pready with no bound of its own.
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the bench timeout ends a hang.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Checks pin levels and register defaults after the first reset.
  task automatic t_defaults();
    chk32("pullups", 32'h7, {29'h0, rpu, spu, ipu});
    chk32("presence", 32'h0, {31'h0, presence_n});
    chk32("drive low", 32'h0, {30'h0, scl_out, sda_out});
    repeat (40) @(posedge pclk);
    apb(1'b0, msbc_pkg::ADDR_CTRL, 32'h0);
    chk32("ctrl", 32'h0, rd);
    apb(1'b0, msbc_pkg::ADDR_MASK, 32'h0);
    chk32("mask", 32'h3, rd);
    apb(1'b0, msbc_pkg::ADDR_STATE, 32'h0);
    chk32("state sw mode", 32'hA2, rd);
    chk32("low power", 32'h0, {31'h0, hp_en});
    apb(1'b0, 8'h10, 32'h0);
    chk32("unmapped data", 32'h0, rd);
    chk32("unmapped err", 32'h1, {31'h0, err});
  endtask
  // Software mode moves to high power only on request.
  task automatic t_sw_power();
    apb(1'b1, msbc_pkg::ADDR_CTRL, 32'h1);
    wait_lvl("hp on", hp_en, 1'b1, 8);
    apb(1'b1, msbc_pkg::ADDR_CTRL, 32'h0);
    wait_lvl("hp off", hp_en, 1'b0, 8);
  endtask
  // Alarms set status, drive the alert and obey the mask.
  task automatic t_alarms();
    apb(1'b1, msbc_pkg::ADDR_STATUS, 32'hF);
    fault <= 1'b1;
    wait_lvl("alert fault", alert_n, 1'b0, 8);
    chk32("irq", 32'h1, {31'h0, irq});
    apb(1'b0, msbc_pkg::ADDR_STATUS, 32'h0);
    chk32("status fault", 32'h1, rd);
    fault <= 1'b0;
    apb(1'b1, msbc_pkg::ADDR_STATUS, 32'h1);
    wait_lvl("alert clear", alert_n, 1'b1, 8);
    rx_alarm <= 1'b1;
    wait_lvl("loss on", loss, 1'b1, 4);
    wait_lvl("alert loss", alert_n, 1'b0, 8);
    rx_alarm <= 1'b0;
    wait_lvl("loss off", loss, 1'b0, 4);
    apb(1'b1, msbc_pkg::ADDR_STATUS, 32'h2);
    apb(1'b1, msbc_pkg::ADDR_MASK, 32'h0);
    fault <= 1'b1;
    repeat (10) @(posedge pclk);
    chk32("masked", 32'h1, {31'h0, alert_n});
    fault <= 1'b0;
    apb(1'b1, msbc_pkg::ADDR_STATUS, 32'h1);
  endtask
  // Serial pins are gated by select, stretching is bounded.
  task automatic t_select();
    scl_hold <= 1'b1;
    repeat (6) @(posedge pclk);
    chk32("deselected", 32'h1, {29'h0, scl_oe, m_en, m_scl});
    sel <= 1'b1;
    wait_lvl("scl held", scl_oe, 1'b1, 8);
    chk32("enabled", 32'h3, {30'h0, m_en, m_sda});
    for (n = 0; n < 40 && scl_oe === 1'b1; n++) @(posedge pclk);
    chk32("stretch", 32'h1, {31'h0, n <= 21});
    scl_hold <= 1'b0;
    sda_low <= 1'b1;
    wait_lvl("sda held", sda_oe, 1'b1, 4);
    sel <= 1'b0;
    wait_lvl("sda freed", sda_oe, 1'b0, 5);
    chk32("scl freed", 32'h0, {31'h0, scl_oe});
    sda_low <= 1'b0;
  endtask
  // Short pulses are ignored; long ones restore defaults.
  task automatic t_reset_pin();
    apb(1'b1, msbc_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, msbc_pkg::ADDR_MASK, 32'h0);
    apb(1'b1, msbc_pkg::ADDR_STATUS, 32'hF);
    hold_rst <= 1'b1;
    repeat (150) @(posedge pclk);
    hold_rst <= 1'b0;
    repeat (8) @(posedge pclk);
    chk32("glitch", 32'h1, {30'h0, in_rst, hp_en});
    hold_rst <= 1'b1;
    repeat (260) @(posedge pclk);
    chk32("in reset", 32'h2, {30'h0, in_rst, hp_en});
    hold_rst <= 1'b0;
    wait_lvl("release", in_rst, 1'b0, 8);
    repeat (20) @(posedge pclk);
    apb(1'b0, msbc_pkg::ADDR_STATUS, 32'h0);
    chk32("status", 32'hC, rd);
    apb(1'b0, msbc_pkg::ADDR_MASK, 32'h0);
    chk32("mask back", 32'h3, rd);
    apb(1'b0, msbc_pkg::ADDR_CTRL, 32'h0);
    chk32("ctrl back", 32'h0, rd);
  endtask
  // A fresh insertion in hardware mode goes to high power alone.
  task automatic t_hw_mode();
    presetn <= 1'b0;
    drv_init <= 1'b1;
    init_lvl <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wait_lvl("hw high power", hp_en, 1'b1, 40);
    apb(1'b0, msbc_pkg::ADDR_STATE, 32'h0);
    chk32("hw state", 32'h183, rd);
  endtask
  // A hang counts as a mismatch and ends the run.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_sw_power();
    t_alarms();
    t_select();
    t_reset_pin();
    t_hw_mode();
    results();
  end
endmodule
`default_nettype wire
